// file: test_windowed_reset_watchdog.sv
// self-checking bench for the windowed reset watchdog
// assumes a 16-cycle prescaler, both startup delays, a zero-wait slave
`timescale 1ns/10ps
module test_windowed_reset_watchdog;
    localparam int          DIV = 16;
    localparam logic [31:0] CA  = {22'h0, wdg_pkg::CTRL_IDX, 2'b00};
    localparam logic [31:0] SA  = {22'h0, wdg_pkg::STAT_IDX, 2'b00};
    localparam logic [31:0] BA  = {22'h0, wdg_pkg::BAD_IDX, 2'b00};
    // =========================================================
    // stimulus and observed signals
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, q, q1, q2;
    logic [1:0]  htrans = 2'b00;
    logic        halt_instr = 1'b0, ext_irq = 1'b0, osc_irq = 1'b0;
    logic        rtc_irq_enable = 1'b0, halt_reset_option = 1'b0;
    logic        hw_wdg_option = 1'b0, hreadyout, hresp, wdg_rst_n;
    logic        long_startup = 1'b0;
    logic        halt_mode, active_halt_mode;
    int          n_fail = 0, num_checks = 0, n_low = 0, base, w, n;
    int          m_act = 0;  // model of the activation bit
    // =========================================================
    // clock, low-cycle tally of the reset pin, design
    always #10 hclk = ~hclk;
    always @(posedge hclk) if (wdg_rst_n === 1'b0) n_low <= n_low + 1;
    windowed_reset_watchdog #(.DIV_CYCLES(DIV)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .halt_instr(halt_instr), .ext_irq(ext_irq),
        .osc_irq(osc_irq), .rtc_irq_enable(rtc_irq_enable),
        .halt_reset_option(halt_reset_option),
        .hw_wdg_option(hw_wdg_option), .long_startup(long_startup),
        .wdg_rst_n(wdg_rst_n), .halt_mode(halt_mode),
        .active_halt_mode(active_halt_mode));
    // =========================================================
    // helpers: cycles, compare, bus transfer, reset-pin wait
    task automatic cyc(input int c);
        repeat (c) @(posedge hclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic wr, input logic [31:0] a, d);
        chk({31'h0, hreadyout}, 32'h1);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge hclk iff hreadyout === 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge hclk iff hreadyout === 1'b1);
        q = hrdata;
        chk({31'h0, hresp}, 32'h0);
        if (!wr && a == CA)
            chk(32'(q[7]), 32'(m_act));
        if (wr && a == CA)
            m_act = m_act | int'(d[7]);
    endtask
    task automatic rst_wait(input int lim);
        w = 0;
        while (wdg_rst_n !== 1'b0 && w < lim)
        begin
            @(posedge hclk);
            w++;
        end
    endtask
    task automatic halt_go();
        halt_instr <= 1'b1;
        @(posedge hclk);
        halt_instr <= 1'b0;
    endtask
    task automatic pulse_chk();
        cyc(40);
        chk(32'(n_low - base), 32'(wdg_pkg::RST_PULSE_CYC));
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // =========================================================
    // hang guard
    initial
    begin
        #200000;
        n_fail++;
        stop_test();
    end
    // =========================================================
    // main sequence
    initial
    begin
        void'($urandom(27));
        cyc(12);
        hresetn <= 1'b1;
        xfer(0, CA, 0); chk(q, 32'h7f);
        xfer(1, BA, 32'hff); xfer(0, BA, 0); chk(q, 0);
        cyc(260);
        // inactive counter steps but never pulls the pin
        base = n_low;
        xfer(1, CA, 32'h41);
        cyc(4 * DIV);
        xfer(0, CA, 0); chk(32'(q >= 32'h3b && q <= 32'h3e), 1);
        chk(32'(n_low - base), 0);
        // activation with a random count of steps before rollover
        n = $urandom_range(3, 1);
        base = n_low;
        xfer(1, CA, 32'hc0 | 32'(n));
        rst_wait(200);
        chk(32'(w > n * DIV && w <= (n + 1) * DIV + 3), 1);
        pulse_chk();
        // writes never clear the activation bit
        xfer(1, CA, 32'h7f); xfer(0, CA, 0);
        chk(q & 32'h80, 32'h80);
        // software reset: activation with top bit clear
        base = n_low;
        xfer(1, CA, 32'h80 | ($urandom & 32'h3f));
        rst_wait(10); chk(32'(w <= 2), 1);
        pulse_chk();
        // halt with reset option while active
        halt_reset_option <= 1'b1;
        xfer(1, CA, 32'hff);
        base = n_low;
        halt_go();
        rst_wait(10); chk(32'(w <= 3), 1);
        chk({31'h0, halt_mode}, 0);
        pulse_chk();
        halt_reset_option <= 1'b0;
        // plain halt: one more step, frozen, startup after wake
        xfer(1, CA, 32'hff);
        halt_go();
        cyc(2); chk({31'h0, halt_mode}, 1);
        cyc(3 * DIV); xfer(0, CA, 0); q1 = q;
        chk(32'(q1 == 32'hfe || q1 == 32'hfd), 1);
        cyc(3 * DIV); xfer(0, CA, 0); chk(q, q1);
        ext_irq <= 1'b1; @(posedge hclk); ext_irq <= 1'b0;
        cyc(2); chk({31'h0, halt_mode}, 0);
        cyc(4 * DIV); xfer(0, CA, 0); chk(q, q1);
        cyc(256); xfer(0, CA, 0); chk(32'(q < q1), 1);
        // active halt: frozen, oscillator interrupt resumes at once
        rtc_irq_enable <= 1'b1;
        halt_go();
        cyc(2); chk({31'h0, active_halt_mode}, 1);
        xfer(0, CA, 0); q2 = q;
        cyc(3 * DIV); xfer(0, CA, 0); chk(q, q2);
        osc_irq <= 1'b1; @(posedge hclk); osc_irq <= 1'b0;
        cyc(2); chk({31'h0, active_halt_mode}, 0);
        cyc(3 * DIV); xfer(0, CA, 0); chk(32'(q < q2), 1);
        // reset out of active halt, long startup delay
        halt_go();
        cyc(4);
        long_startup <= 1'b1;
        hresetn <= 1'b0;
        m_act = 0;
        cyc(2);
        hresetn <= 1'b1;
        xfer(0, CA, 0); chk(q, 32'h7f);
        cyc(150); xfer(0, CA, 0); chk(q, 32'h7f);
        cyc(250); xfer(0, CA, 0); chk(q, 32'h7f);
        rtc_irq_enable <= 1'b0;
        // hardware option: rollover resets without the activation bit
        hw_wdg_option <= 1'b1;
        cyc(3800);
        xfer(0, SA, 0); chk(q & 32'h1, 32'h1);
        base = n_low;
        xfer(1, CA, 32'h41);
        rst_wait(200); chk(32'(w > DIV && w <= 2 * DIV + 3), 1);
        pulse_chk();
        stop_test();
    end
endmodule

// file: wdg_pkg.sv
// constants, states and register map of the windowed reset watchdog
// assumes one 50 MHz clock that also stands for the oscillator clock
package wdg_pkg;

    // =========================================================
    // register map (offsets are word indices, byte = 4 x idx)
    localparam logic [7:0]  CTRL_IDX  = 8'h2a;  // control register
    localparam logic [7:0]  STAT_IDX  = 8'h2b;  // status register
    localparam logic [7:0]  BAD_IDX   = 8'hff;  // unmapped marker
    localparam logic [7:0]  CTRL_RST  = 8'h7f;  // control reset value
    localparam int          ACT_BIT   = 7;      // activation_bit
    localparam int          TOP_BIT   = 6;      // count_top_bit
    localparam logic [6:0]  ROLL_FROM = 7'h40;  // value before rollover

    // status register fields
    localparam int ST_ACTIVE_BIT = 0;
    localparam int ST_HALT_BIT   = 1;
    localparam int ST_AHALT_BIT  = 2;
    localparam int ST_START_BIT  = 3;
    localparam int ST_PULSE_BIT  = 4;

    // =========================================================
    // timing
    localparam int CLK_MHZ       = 50;
    localparam int DIV_OSC_CYC   = 16384;  // oscillator cycles per step
    localparam int RST_PULSE_NS  = 500;
    localparam int RST_PULSE_CYC = RST_PULSE_NS * CLK_MHZ / 1000;
    localparam int START_SHORT   = 256;    // cpu clocks
    localparam int START_LONG    = 4096;   // cpu clocks

    // =========================================================
    // power state of the counter
    typedef enum logic [4:0]
    {
        ST_RUN      = 5'h01,
        ST_HALT_ONE = 5'h02,
        ST_HALT     = 5'h04,
        ST_AHALT    = 5'h08,
        ST_START    = 5'h10
    } wdg_state_e;

endpackage

// file: windowed_reset_watchdog.sv
// windowed reset watchdog with an ahb-lite register slave
// assumes power-mode inputs synchronous to hclk, hclk as oscillator
//
// Operation
// R01 - count steps once per 16384 oscillator cycles
// R02 - low six count bits set timeout
// R03 - active rollover 40h to 3Fh pulses reset
// R04 - inactive counter keeps counting, never resets
// R05 - software refreshes with values C0h to FFh
// R06 - any reset deactivates; writes never deactivate; its own pulse on wdg_rst_n leaves the bit set
// R07 - activate with top bit clear: software reset
// R08 - writes leave the prescaler phase untouched
// R09 - halt, no rtc irq, option set: reset
// R10 - plain halt: one step, then freeze
// R11 - external wake from halt: startup delay
// R12 - reset leaves watchdog off unless hardware option
// R13 - active halt freezes, interrupt resumes at once
// R14 - reset from active halt: startup delay
// R15 - hardware option forces watchdog always active
// R16 - control: bit7 activation, bits6..0 count, 7Fh
// R17 - software refreshes before halt
// R18 - write loads count; activation only sets
//
// Local design decisions: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
module windowed_reset_watchdog #(
    parameter int DIV_CYCLES = wdg_pkg::DIV_OSC_CYC
) (
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // power modes and options
    input  wire logic        halt_instr,
    input  wire logic        ext_irq,
    input  wire logic        osc_irq,
    input  wire logic        rtc_irq_enable,
    input  wire logic        halt_reset_option,
    input  wire logic        hw_wdg_option,
    input  wire logic        long_startup,
    // reset pin and mode view
    output logic             wdg_rst_n,
    output logic             halt_mode,
    output logic             active_halt_mode
);

    localparam int DIV_W = $clog2(DIV_CYCLES);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV_CYCLES - 1);
    localparam logic [4:0] PULSE_LEN = 5'(wdg_pkg::RST_PULSE_CYC);

    typedef struct packed {
        logic                   act;
        logic [6:0]             cnt;
        logic [DIV_W-1:0]       div;
        wdg_pkg::wdg_state_e    st;
        logic [11:0]            start;
        logic [4:0]             pcnt;
        logic                   rst_n;
        logic                   pend;
        logic                   wr;
        logic [7:0]             idx;
        logic [31:0]            rdata;
        logic                   ready;
        logic                   halt;
        logic                   ahalt;
    } wdg_s;

    wdg_s        s_r;
    wdg_s        s_nxt;
    logic        tick;
    logic        dec;
    logic        active;
    logic        wr_ctl;
    logic        roll;
    logic        sw_rst;
    logic        halt_rst;
    logic [11:0] start_lim;

    // =========================================================
    // next-state logic
    always_comb
    begin
        s_nxt    = s_r;
        dec      = 1'b0;
        roll     = 1'b0;
        sw_rst   = 1'b0;
        halt_rst = 1'b0;
        active   = s_r.act | hw_wdg_option;                  // [R15]
        start_lim = long_startup ? 12'(wdg_pkg::START_LONG - 1)
                                 : 12'(wdg_pkg::START_SHORT - 1);

        // free prescaler, never cleared by a write          // [R08]
        tick = (s_r.div == '0);
        s_nxt.div = tick ? DIV_LAST : s_r.div - 1'b1;        // [R01]

        // power state of the counter
        case (s_r.st)
            wdg_pkg::ST_RUN:
            begin
                dec = tick;                                  // [R04]
                if (halt_instr)
                begin
                    if (rtc_irq_enable)
                        s_nxt.st = wdg_pkg::ST_AHALT;        // [R13]
                    else if (halt_reset_option && active)
                        halt_rst = 1'b1;                     // [R09]
                    else
                        s_nxt.st = wdg_pkg::ST_HALT_ONE;     // [R10]
                end
            end
            wdg_pkg::ST_HALT_ONE:
            begin
                // one last step, with no reset from it
                dec = tick;                                  // [R10]
                if (ext_irq)
                    s_nxt.st = wdg_pkg::ST_START;            // [R11]
                else if (tick)
                    s_nxt.st = wdg_pkg::ST_HALT;
            end
            wdg_pkg::ST_HALT:
            begin
                if (ext_irq)
                    s_nxt.st = wdg_pkg::ST_START;            // [R11]
            end
            wdg_pkg::ST_AHALT:
            begin
                if (osc_irq || ext_irq)
                    s_nxt.st = wdg_pkg::ST_RUN;              // [R13]
            end
            wdg_pkg::ST_START:
            begin
                // startup delay before counting resumes
                if (s_r.start == start_lim)
                    s_nxt.st = wdg_pkg::ST_RUN;              // [R11] [R14]
            end
            default:
            begin
                s_nxt.st = wdg_pkg::ST_RUN;
            end
        endcase
        s_nxt.start = (s_nxt.st == wdg_pkg::ST_START)
                    ? s_r.start + 1'b1 : '0;
        if (s_r.st != wdg_pkg::ST_START && s_nxt.st == wdg_pkg::ST_START)
            s_nxt.start = '0;

        // down-counter, rollover only counts in run state
        if (dec)
        begin
            s_nxt.cnt = s_r.cnt - 1'b1;
            roll = active && (s_r.st == wdg_pkg::ST_RUN)
                   && (s_r.cnt == wdg_pkg::ROLL_FROM);       // [R03] [R02]
        end

        // data phase of a write to the control register
        wr_ctl = s_r.pend && s_r.wr && (s_r.idx == wdg_pkg::CTRL_IDX);
        if (wr_ctl)
        begin
            roll = 1'b0;
            s_nxt.cnt = hwdata[6:0];                         // [R18]
            s_nxt.act = s_r.act | hwdata[wdg_pkg::ACT_BIT];  // [R06]
            sw_rst = (s_nxt.act | hw_wdg_option)
                     && !hwdata[wdg_pkg::TOP_BIT];           // [R07]
        end

        // reset pulse on the pin, one at a time
        if ((roll || sw_rst || halt_rst) && s_r.pcnt == '0)
        begin
            s_nxt.pcnt  = PULSE_LEN;                         // [R03]
            s_nxt.rst_n = 1'b0;
        end
        else if (s_r.pcnt != '0)
        begin
            s_nxt.pcnt  = s_r.pcnt - 1'b1;
            s_nxt.rst_n = (s_r.pcnt == 5'h01);
        end

        // address phase capture, zero wait states
        s_nxt.ready = 1'b1;
        s_nxt.pend  = 1'b0;
        s_nxt.rdata = '0;
        if (hready && hsel && htrans[1])
        begin
            s_nxt.pend = 1'b1;
            s_nxt.wr   = hwrite;
            if (haddr[31:10] == '0 && haddr[1:0] == 2'h0)
                s_nxt.idx = haddr[9:2];
            else
                s_nxt.idx = wdg_pkg::BAD_IDX;
            // read data from the state after any write
            if (!hwrite && s_nxt.idx == wdg_pkg::CTRL_IDX)
                s_nxt.rdata = {24'h0, s_nxt.act, s_nxt.cnt};   // [R16]
            else if (!hwrite && s_nxt.idx == wdg_pkg::STAT_IDX)
            begin
                s_nxt.rdata[wdg_pkg::ST_ACTIVE_BIT] = s_nxt.act
                                                    | hw_wdg_option;
                s_nxt.rdata[wdg_pkg::ST_HALT_BIT]  =
                    (s_nxt.st == wdg_pkg::ST_HALT)
                    || (s_nxt.st == wdg_pkg::ST_HALT_ONE);
                s_nxt.rdata[wdg_pkg::ST_AHALT_BIT] =
                    (s_nxt.st == wdg_pkg::ST_AHALT);
                s_nxt.rdata[wdg_pkg::ST_START_BIT] =
                    (s_nxt.st == wdg_pkg::ST_START);
                s_nxt.rdata[wdg_pkg::ST_PULSE_BIT] = !s_nxt.rst_n;
            end
        end

        s_nxt.halt  = (s_nxt.st == wdg_pkg::ST_HALT)
                    || (s_nxt.st == wdg_pkg::ST_HALT_ONE);
        s_nxt.ahalt = (s_nxt.st == wdg_pkg::ST_AHALT);
    end

    // =========================================================
    // state register; hresetn clears the activation bit, the pulse on wdg_rst_n does not
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            s_r       <= '0;
            s_r.act   <= 1'b0;                               // [R06] [R12]
            s_r.cnt   <= wdg_pkg::CTRL_RST[6:0];             // [R16]
            s_r.div   <= DIV_LAST;
            s_r.st    <= wdg_pkg::ST_START;                  // [R14]
            s_r.rst_n <= 1'b1;
            s_r.ready <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from flops
    assign hreadyout        = s_r.ready;
    assign hrdata           = s_r.rdata;
    assign hresp            = 1'b0 & s_r.ready;
    assign wdg_rst_n        = s_r.rst_n;
    assign halt_mode        = s_r.halt;
    assign active_halt_mode = s_r.ahalt;

    // =========================================================
    // assertions
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence roll_seq;
        tick && s_r.st == wdg_pkg::ST_RUN && !wr_ctl
        && s_r.cnt == wdg_pkg::ROLL_FROM && s_r.pcnt == '0
        && (s_r.act || hw_wdg_option);
    endsequence

    sequence pulse_seq;
        !wdg_rst_n [*8];
    endsequence

    AST_STEP: assert property (                              // [R01]
        (tick && s_r.st == wdg_pkg::ST_RUN && !wr_ctl)
        |=> s_r.cnt == $past(s_r.cnt) - 7'h01)
        else $error("counter did not step on prescaler tick");

    AST_ROLL_RESET: assert property (                        // [R03]
        roll_seq |=> pulse_seq)
        else $error("rollover while active gave no reset pulse");

    AST_PULSE_LEN: assert property (                         // [R03]
        $fell(wdg_rst_n) |-> s_r.pcnt == PULSE_LEN
        ##24 s_r.pcnt == 5'h01 ##1 wdg_rst_n)
        else $error("reset pulse length wrong");

    AST_QUIET: assert property (                             // [R04]
        (!s_r.act && !hw_wdg_option && !wr_ctl && wdg_rst_n)
        |=> wdg_rst_n)
        else $error("inactive watchdog drove reset");

    AST_STICKY: assert property (                            // [R06]
        s_r.act |=> s_r.act)
        else $error("activation bit cleared without reset");

    AST_SW_RESET: assert property (                          // [R07]
        (wr_ctl && hwdata[7] && !hwdata[6] && s_r.pcnt == '0)
        |=> !wdg_rst_n)
        else $error("software reset not produced");

    AST_LOAD: assert property (                              // [R18]
        wr_ctl |=> s_r.cnt == $past(hwdata[6:0]))
        else $error("write did not load counter");

    AST_HALT_RESET: assert property (                        // [R09]
        (s_r.st == wdg_pkg::ST_RUN && halt_instr && !rtc_irq_enable
         && halt_reset_option && s_r.act && s_r.pcnt == '0)
        |=> !wdg_rst_n)
        else $error("halt with reset option gave no reset");

    AST_HALT_FREEZE: assert property (                       // [R10]
        (s_r.st == wdg_pkg::ST_HALT && !wr_ctl) |=> $stable(s_r.cnt))
        else $error("counter moved while halted");

    AST_AHALT_WAKE: assert property (                        // [R13]
        (s_r.st == wdg_pkg::ST_AHALT && (osc_irq || ext_irq))
        |=> s_r.st == wdg_pkg::ST_RUN)
        else $error("active halt did not resume at once");

    AST_HALT_WAKE: assert property (                         // [R11]
        (s_r.st == wdg_pkg::ST_HALT && ext_irq)
        |=> s_r.st == wdg_pkg::ST_START && s_r.start == '0)
        else $error("halt wake skipped startup delay");

endmodule
